// ---- pmc_params.svh ----
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_BOR_LVL_RST      3'h0
`define PMC_WAKE_SRC_W       8
`define PMC_CLK_MSI          2'h0
`define PMC_CLK_HSI          2'h1
`define PMC_CLK_HSI_LIM      2'h2
`define PMC_IO_FLOAT         2'h0
`define PMC_IO_PULLUP        2'h1
`define PMC_IO_PULLDN        2'h2
`define PMC_IO_W             8
`endif

// ---- pmc_pkg.sv ----
`include "pmc_params.svh"
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_M_RUN, PMC_M_SLEEP, PMC_M_LPRUN, PMC_M_LPSLEEP,
        PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2, PMC_M_STANDBY
    } pmc_mode_t;
    typedef struct packed {
        logic main_regulator;
        logic low_power_regulator;
        logic radio_regulator;
        logic core_supply_domain;
        logic core_low_leak;
        logic cpu_clk_en;
        logic cpu_clk_limit;
        logic main_ram_bank;
        logic retainable_ram_bank;
        logic second_ram_bank_b;
        logic reg_retain;
        logic low_speed_osc;
        logic internal_16mhz_rc;
    } pmc_pwr_t;
    typedef struct packed {
        logic external_reset_pin;
        logic independent_watchdog;
        logic wake_pin;
        logic rtc_event;
        logic low_speed_crystal_fail;
        logic radio_wake;
        logic irq_event;
    } pmc_wake_t;
    typedef struct packed {
        pmc_mode_t                  mode;
        logic [1:0]                 sysclk_sel;
        logic                       pvd_flag;
        logic                       pvd_prev;
        logic                       io_standby;
        logic [2:0]                 bor_level;
        logic                       bor_caught;
    } pmc_state_t;
endpackage : pmc_pkg

// ---- pmc_power_mode_controller.sv ----
// Behaviour
// - main regulator in run, sleep, stop0
// - low-power regulator for lp modes, retention
// - radio regulator follows radio request outside standby, lp run and lp sleep
// - main and radio regulators off in standby, low-power kept only for bank retention
// - lp run limits cpu clock, hsi allowed
// - brownout holds reset below threshold
// - lowest threshold at power-on, option raise
// - voltage detector interrupt on selected edges
// - run after reset, low-power only on request
// - sleep stops only cpu, any irq wakes
// - lp run excludes radio, cpu limited
// - lp sleep only from lp run
// - stop retains ram, registers, low-speed osc
// - wake peripherals may enable 16 mhz rc
// - stop0 keeps main, stop2 low leakage
// - stop exit clock msi or internal_16mhz_rc
// - radio may wait for events in stop
// - standby: core off, brownout active
// - software chosen io state in standby
// - standby loses ram except optional bank 2a
// - standby exits on listed wake sources
// - standby wake gives 16 mhz rc clock
// - effective state is higher of both requests
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire pmc_pkg::pmc_mode_t   cpu_mode_sel,
    input  wire logic                 cpu_halted,
    input  wire pmc_pkg::pmc_mode_t   radio_mode_req,
    input  wire logic                 radio_active,
    input  wire logic                 radio_reg_req,
    input  wire logic                 retainable_ram_bank_retain_en,
    input  wire logic                 stop_exit_hsi,
    input  wire logic [1:0]           io_pull_sel,
    input  wire pmc_pkg::pmc_wake_t   wake,
    input  wire logic                 periph_hsi_req,
    input  wire logic                 vdd_below_bor,
    input  wire logic [2:0]           bor_level_opt,
    input  wire logic                 voltage_detector_en,
    input  wire logic                 vdd_below_pvd,
    input  wire logic                 pvd_irq_fall_en,
    input  wire logic                 pvd_irq_rise_en,
    input  wire logic                 pvd_flag_clr,
    output pmc_pkg::pmc_mode_t        eff_mode,
    output pmc_pkg::pmc_pwr_t         pwr,
    output logic [1:0]                sysclk_sel,
    output logic [1:0]                io_standby_state,
    output logic [2:0]                bor_level,
    output logic                      sys_reset_n,
    output logic                      voltage_detector_irq
);
    import pmc_pkg::*;

    pmc_state_t st_r;
    pmc_state_t st_nxt;

    // deeper request has the higher code; the lower code wins, and run wins over all
    function automatic pmc_mode_t pmc_higher(input pmc_mode_t a, input pmc_mode_t b);
        if (a == PMC_M_RUN || b == PMC_M_RUN)
            return PMC_M_RUN;
        return (a < b) ? a : b;
    endfunction : pmc_higher

    function automatic logic pmc_is_stop(input pmc_mode_t m);
        return (m == PMC_M_STOP0) || (m == PMC_M_STOP1) || (m == PMC_M_STOP2);
    endfunction : pmc_is_stop

    logic       any_wake;
    logic       stby_wake;
    pmc_mode_t  req_mode;

    always_comb begin
        any_wake  = |wake;
        stby_wake = wake.external_reset_pin | wake.independent_watchdog | wake.wake_pin
                  | wake.rtc_event | wake.low_speed_crystal_fail | wake.radio_wake;
        req_mode  = pmc_higher(cpu_mode_sel, radio_active ? radio_mode_req : PMC_M_STANDBY);
        st_nxt    = st_r;
        st_nxt.pvd_prev = vdd_below_pvd;
        // caught once after release; later option changes need a reset
        if (!st_r.bor_caught) begin
            st_nxt.bor_caught = 1'b1;
            st_nxt.bor_level  = bor_level_opt;
        end
        case (st_r.mode)
            PMC_M_RUN: begin
                // lp sleep direct request is refused from run
                if (cpu_halted && req_mode != PMC_M_RUN && req_mode != PMC_M_LPSLEEP) begin
                    st_nxt.mode = req_mode;
                end else if (!cpu_halted && cpu_mode_sel == PMC_M_LPRUN && !radio_active) begin
                    st_nxt.mode = PMC_M_LPRUN;
                end
            end
            PMC_M_SLEEP: begin
                if (any_wake)
                    st_nxt.mode = PMC_M_RUN;
            end
            PMC_M_LPRUN: begin
                if (radio_active || cpu_mode_sel == PMC_M_RUN)
                    st_nxt.mode = PMC_M_RUN;
                else if (cpu_halted && cpu_mode_sel == PMC_M_LPSLEEP)
                    st_nxt.mode = PMC_M_LPSLEEP;
            end
            PMC_M_LPSLEEP: begin
                if (any_wake)
                    st_nxt.mode = PMC_M_LPRUN;
            end
            PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2: begin
                if (any_wake) begin
                    st_nxt.mode = PMC_M_RUN;
                    st_nxt.sysclk_sel = (stop_exit_hsi || radio_active) ?
                                        `PMC_CLK_HSI : `PMC_CLK_MSI;
                end
            end
            PMC_M_STANDBY: begin
                if (stby_wake) begin
                    st_nxt.mode       = PMC_M_RUN;
                    st_nxt.sysclk_sel = `PMC_CLK_HSI;
                end
            end
            default: st_nxt.mode = PMC_M_RUN;
        endcase
        // pin states follow the mode on the same edge, no stale pull after wake
        st_nxt.io_standby = (st_nxt.mode == PMC_M_STANDBY);
        if (st_nxt.mode == PMC_M_LPRUN || st_nxt.mode == PMC_M_LPSLEEP)
            st_nxt.sysclk_sel = `PMC_CLK_HSI_LIM;
        else if (st_r.mode == PMC_M_LPRUN && st_nxt.mode == PMC_M_RUN)
            st_nxt.sysclk_sel = `PMC_CLK_MSI;
        // set beats clear so a crossing during the clear is kept
        if (voltage_detector_en &&
            ((pvd_irq_fall_en && vdd_below_pvd && !st_r.pvd_prev) ||
             (pvd_irq_rise_en && !vdd_below_pvd && st_r.pvd_prev)))
            st_nxt.pvd_flag = 1'b1;
        else if (pvd_flag_clr)
            st_nxt.pvd_flag = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{mode: PMC_M_RUN, sysclk_sel: `PMC_CLK_MSI, pvd_flag: 1'b0,
                      pvd_prev: 1'b0, io_standby: 1'b0, bor_level: `PMC_BOR_LVL_RST,
                      bor_caught: 1'b0};
        end else if (vdd_below_bor) begin
            // brownout resets only the mode and io standby; clock select, flags and bor level are kept
            st_r.io_standby <= 1'b0;
            st_r.mode       <= PMC_M_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    pmc_mode_t m;
    always_comb begin
        m   = st_r.mode;
        pwr = '0;
        pwr.main_regulator      = (m == PMC_M_RUN) || (m == PMC_M_SLEEP)
                                || (m == PMC_M_STOP0);
        pwr.low_power_regulator = (m == PMC_M_LPRUN) || (m == PMC_M_LPSLEEP)
                                || (m == PMC_M_STOP1) || (m == PMC_M_STOP2)
                                || (m == PMC_M_STANDBY && retainable_ram_bank_retain_en);
        pwr.radio_regulator     = radio_reg_req && m != PMC_M_STANDBY
                                && m != PMC_M_LPRUN && m != PMC_M_LPSLEEP;
        pwr.core_supply_domain  = (m != PMC_M_STANDBY);
        pwr.core_low_leak       = (m == PMC_M_STOP2);
        pwr.cpu_clk_en          = (m == PMC_M_RUN) || (m == PMC_M_LPRUN);
        pwr.cpu_clk_limit       = (m == PMC_M_LPRUN);
        pwr.main_ram_bank       = (m != PMC_M_STANDBY);
        pwr.second_ram_bank_b   = (m != PMC_M_STANDBY);
        pwr.retainable_ram_bank = (m != PMC_M_STANDBY) || retainable_ram_bank_retain_en;
        pwr.reg_retain          = (m != PMC_M_STANDBY);
        pwr.low_speed_osc       = 1'b1;
        pwr.internal_16mhz_rc   = pmc_is_stop(m) ? periph_hsi_req : 1'b1;
    end

    assign eff_mode             = st_r.mode;
    assign sysclk_sel           = st_r.sysclk_sel;
    assign io_standby_state     = st_r.io_standby ? io_pull_sel : `PMC_IO_FLOAT;
    assign bor_level            = st_r.bor_level;
    assign sys_reset_n          = !vdd_below_bor;
    assign voltage_detector_irq = st_r.pvd_flag;

    run_after_reset_a: assert property (
        @(posedge clk) $rose(rst_n) |-> eff_mode == PMC_M_RUN)
        else $error("mode not run after reset");

    run_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_RUN && !cpu_halted && cpu_mode_sel != PMC_M_LPRUN)
        |=> eff_mode == PMC_M_RUN)
        else $error("mode left run without halt");

    lpsleep_entry_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_LPSLEEP && $changed(eff_mode)) |-> $past(eff_mode) == PMC_M_LPRUN)
        else $error("lp sleep not from lp run");

    lpsleep_wake_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_LPSLEEP && (|wake) && !vdd_below_bor) |=> eff_mode == PMC_M_LPRUN)
        else $error("lp sleep did not return to lp run");

    run_main_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_RUN || eff_mode == PMC_M_SLEEP) |-> pwr.main_regulator)
        else $error("main regulator off in run");

    main_reg_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STOP0) |-> pwr.main_regulator && !pwr.core_low_leak)
        else $error("stop0 main regulator off");

    stop2_leak_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STOP2) |-> pwr.core_low_leak && !pwr.main_regulator)
        else $error("stop2 not in low leakage");

    lpr_modes_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode inside {PMC_M_LPRUN, PMC_M_LPSLEEP, PMC_M_STOP1, PMC_M_STOP2})
        |-> pwr.low_power_regulator && !pwr.main_regulator)
        else $error("low-power regulator not in use");

    radio_follow_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode inside {PMC_M_RUN, PMC_M_SLEEP, PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2})
        |-> pwr.radio_regulator == radio_reg_req)
        else $error("radio regulator ignores radio request");

    standby_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STANDBY) |-> !pwr.main_regulator && !pwr.radio_regulator
        && !pwr.core_supply_domain)
        else $error("regulator on in standby");

    lp_clock_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_LPRUN) |-> pwr.cpu_clk_limit && !pwr.main_regulator
        && sysclk_sel == `PMC_CLK_HSI_LIM)
        else $error("lp run clock not limited");

    bor_reset_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        vdd_below_bor |=> eff_mode == PMC_M_RUN)
        else $error("brownout did not reset mode");

    bor_out_a: assert property (
        @(posedge clk) vdd_below_bor |-> !sys_reset_n)
        else $error("reset not held in brownout");

    bor_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        st_r.bor_caught |=> $stable(bor_level))
        else $error("brownout level moved after capture");

    pvd_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (voltage_detector_en && pvd_irq_fall_en && vdd_below_pvd && !st_r.pvd_prev
        && !vdd_below_bor) |=> voltage_detector_irq)
        else $error("falling supply not flagged");

    pvd_quiet_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!voltage_detector_en && !voltage_detector_irq) |=> !voltage_detector_irq)
        else $error("detector flag set while disabled");

    pvd_sticky_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (voltage_detector_irq && !pvd_flag_clr) |=> voltage_detector_irq)
        else $error("detector flag dropped");

    sleep_wake_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_SLEEP && wake.irq_event) |=> eff_mode == PMC_M_RUN)
        else $error("sleep did not wake");

    sleep_cpu_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_SLEEP) |-> !pwr.cpu_clk_en && pwr.main_regulator)
        else $error("cpu clock running in sleep");

    lprun_radio_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_LPRUN && radio_active && !vdd_below_bor) |=> eff_mode == PMC_M_RUN)
        else $error("lp run kept with radio active");

    stop_retain_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode inside {PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2})
        |-> pwr.main_ram_bank && pwr.reg_retain && pwr.low_speed_osc)
        else $error("stop lost retention");

    stop_hsi_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode inside {PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2})
        |-> pwr.internal_16mhz_rc == periph_hsi_req)
        else $error("rc not under peripheral control in stop");

    stop_exit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(eff_mode) inside {PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2} && eff_mode == PMC_M_RUN
        && !$past(vdd_below_bor) && $past(stop_exit_hsi)) |-> sysclk_sel == `PMC_CLK_HSI)
        else $error("stop exit clock not rc");

    stby_clock_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($past(eff_mode) == PMC_M_STANDBY && eff_mode == PMC_M_RUN && !$past(vdd_below_bor))
        |-> sysclk_sel == `PMC_CLK_HSI)
        else $error("standby wake clock wrong");

    standby_ram_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STANDBY) |-> !pwr.main_ram_bank && !pwr.second_ram_bank_b
        && !pwr.reg_retain && pwr.retainable_ram_bank == retainable_ram_bank_retain_en)
        else $error("standby retention wrong");

    standby_io_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        io_standby_state == ((eff_mode == PMC_M_STANDBY) ? io_pull_sel : `PMC_IO_FLOAT))
        else $error("io standby state wrong");

    standby_wake_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STANDBY && wake.wake_pin && !vdd_below_bor) |=> eff_mode == PMC_M_RUN)
        else $error("wake pin did not leave standby");

    standby_stay_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_STANDBY && wake == 7'h01 && !vdd_below_bor)
        |=> eff_mode == PMC_M_STANDBY)
        else $error("plain interrupt left standby");

    higher_req_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_RUN && cpu_halted && radio_active && radio_mode_req == PMC_M_RUN)
        |=> eff_mode == PMC_M_RUN)
        else $error("radio run request overridden");

    higher_mode_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (eff_mode == PMC_M_RUN && cpu_halted && radio_active && radio_mode_req == PMC_M_SLEEP
        && cpu_mode_sel inside {PMC_M_STOP0, PMC_M_STOP1, PMC_M_STOP2} && !vdd_below_bor)
        |=> eff_mode == PMC_M_SLEEP)
        else $error("radio sleep request not kept");
endmodule : pmc_power_mode_controller
`default_nettype wire

// ---- pmc_sw_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_sw_model
    import pmc_pkg::*;
(
    input  wire logic      clk,
    input  wire pmc_mode_t want_mode,
    input  wire logic      want_halt,
    input  wire logic      radio_on,
    output pmc_mode_t      cpu_mode_sel,
    output logic           cpu_halted,
    output logic           radio_active,
    output logic           stop_exit_hsi
);
    // selection is written first, the halt follows a cycle later
    assign cpu_mode_sel = want_mode;
    always @(negedge clk) begin
        cpu_halted <= want_halt;
    end
    // radio is shut down whenever the low-power run family is chosen
    assign radio_active  = radio_on & !(want_mode inside {PMC_M_LPRUN, PMC_M_LPSLEEP});
    assign stop_exit_hsi = radio_on;
endmodule : pmc_sw_model
`default_nettype wire

// ---- tb_power_mode_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_power_mode_controller;
    import pmc_pkg::*;
    logic clk, rst_n, want_halt, radio_on, radio_reg_req, ret, halted, r_act, exit_hsi;
    logic vdd_below_bor, pvd_en, below_pvd, fall_en, rise_en, pvd_clr, sys_reset_n, irq;
    logic hsi_req;
    logic [1:0] io_sel, sysclk_sel, io_st;
    logic [2:0] bor_opt, bor_level;
    pmc_mode_t want_mode, radio_req, sel, eff_mode;
    pmc_wake_t wake;
    pmc_pwr_t  pwr;
    int        n_errors, num_checks, cycles, k;
    integer    seed;
    pmc_sw_model sw (.clk(clk), .want_mode(want_mode), .want_halt(want_halt),
        .radio_on(radio_on), .cpu_mode_sel(sel), .cpu_halted(halted),
        .radio_active(r_act), .stop_exit_hsi(exit_hsi));
    pmc_power_mode_controller dut (.clk(clk), .rst_n(rst_n), .cpu_mode_sel(sel),
        .cpu_halted(halted), .radio_mode_req(radio_req), .radio_active(r_act),
        .radio_reg_req(radio_reg_req), .retainable_ram_bank_retain_en(ret), .stop_exit_hsi(exit_hsi),
        .io_pull_sel(io_sel), .wake(wake), .periph_hsi_req(hsi_req),
        .vdd_below_bor(vdd_below_bor), .bor_level_opt(bor_opt), .voltage_detector_en(pvd_en),
        .vdd_below_pvd(below_pvd), .pvd_irq_fall_en(fall_en), .pvd_irq_rise_en(rise_en),
        .pvd_flag_clr(pvd_clr), .eff_mode(eff_mode), .pwr(pwr), .sysclk_sel(sysclk_sel),
        .io_standby_state(io_st), .bor_level(bor_level), .sys_reset_n(sys_reset_n),
        .voltage_detector_irq(irq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [2:0] exp_pwr(pmc_mode_t m, logic r);
        exp_pwr[2] = m inside {PMC_M_RUN, PMC_M_SLEEP, PMC_M_STOP0};
        exp_pwr[1] = (m inside {PMC_M_LPRUN, PMC_M_LPSLEEP, PMC_M_STOP1, PMC_M_STOP2})
                     | (m == PMC_M_STANDBY && r);
        exp_pwr[0] = m != PMC_M_STANDBY;
    endfunction : exp_pwr
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_mode(pmc_mode_t exp);
        num_checks++;
        if (eff_mode !== exp) begin
            n_errors++;
            $display("wrong value eff_mode expected %s seen %s", exp.name(), eff_mode.name());
        end
    endtask : chk_mode
    task automatic go(pmc_mode_t m, logic h);
        want_mode <= m;
        want_halt <= h;
        repeat (2) @(negedge clk);
        want_halt <= 1'b0;
    endtask : go
    task automatic wake_up(int b);
        wake <= pmc_wake_t'(7'h01 << b);
        @(negedge clk);
        wake <= '0;
    endtask : wake_up
    task automatic pvd_step(logic below, logic exp);
        below_pvd <= below;
        repeat (2) @(negedge clk);
        chk("pvd_irq", exp, irq);
    endtask : pvd_step
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        seed = 32'h479c;
        {rst_n, want_halt, radio_on, radio_reg_req, ret, vdd_below_bor, pvd_en} = '0;
        {below_pvd, fall_en, rise_en, pvd_clr, io_sel, hsi_req} = '0;
        want_mode = PMC_M_RUN;
        radio_req = PMC_M_STANDBY;
        wake      = '0;
        bor_opt   = 3'($random(seed));
        repeat (4) @(negedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_mode(PMC_M_RUN);
        chk("bor_level", bor_opt, bor_level);
        for (int i = 1; i < 8; i++) begin
            if (i == 2 || i == 3) continue;
            ret      <= 1'($random(seed));
            io_sel   <= 2'({$random(seed)} % 3);
            hsi_req  <= 1'($random(seed));
            radio_on <= (i >= 4 && i < 7) ? 1'($random(seed)) : 1'b0;
            go(pmc_mode_t'(i), 1'b1);
            chk_mode(pmc_mode_t'(i));
            chk("pwr", exp_pwr(pmc_mode_t'(i), ret), {pwr.main_regulator,
                pwr.low_power_regulator, pwr.core_supply_domain});
            chk("leak_clk", {i == 6, 1'b0}, {pwr.core_low_leak, pwr.cpu_clk_en});
            if (i == 7) begin
                chk("io_state", io_sel, io_st);
                chk("ram", {ret, 3'h0}, {pwr.retainable_ram_bank, pwr.main_ram_bank,
                    pwr.second_ram_bank_b, pwr.reg_retain});
                wake_up(0);
                chk_mode(PMC_M_STANDBY);
            end
            else if (i > 3) begin
                chk("lso", 1'b1, pwr.low_speed_osc);
                chk("internal_16mhz_rc", hsi_req, pwr.internal_16mhz_rc);
            end
            k = 1 + {$random(seed)} % 6;
            wake_up(k);
            chk_mode(PMC_M_RUN);
            if (i > 3) chk("sysclk", (i == 7 || radio_on) ? 2'h1 : 2'h0, sysclk_sel);
        end
        go(PMC_M_LPSLEEP, 1'b1);
        chk_mode(PMC_M_RUN);
        radio_on <= 1'b1;
        go(PMC_M_LPRUN, 1'b0);
        chk_mode(PMC_M_LPRUN);
        chk("lprun", {exp_pwr(PMC_M_LPRUN, 1'b0), 1'b1},
            {pwr.main_regulator, pwr.low_power_regulator, pwr.core_supply_domain,
             pwr.cpu_clk_limit});
        chk("sysclk", 2'h2, sysclk_sel);
        go(PMC_M_LPSLEEP, 1'b1);
        chk_mode(PMC_M_LPSLEEP);
        wake_up(0);
        chk_mode(PMC_M_LPRUN);
        go(PMC_M_RUN, 1'b0);
        chk_mode(PMC_M_RUN);
        radio_req <= PMC_M_SLEEP;
        go(PMC_M_STOP2, 1'b1);
        chk_mode(PMC_M_SLEEP);
        wake_up(0);
        radio_on <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            radio_reg_req <= 1'($random(seed));
            @(negedge clk);
            chk("radio_reg", radio_reg_req, pwr.radio_regulator);
        end
        go(PMC_M_SLEEP, 1'b1);
        vdd_below_bor <= 1'b1;
        @(negedge clk);
        chk("sys_reset_n", 1'b0, sys_reset_n);
        chk_mode(PMC_M_RUN);
        vdd_below_bor <= 1'b0;
        {pvd_en, fall_en} <= 2'b11;
        pvd_step(1'b1, 1'b1);
        pvd_step(1'b0, 1'b1);
        pvd_clr <= 1'b1;
        @(negedge clk);
        pvd_clr <= 1'b0;
        @(negedge clk);
        chk("pvd_irq", 1'b0, irq);
        {fall_en, rise_en} <= 2'b01;
        pvd_step(1'b1, 1'b0);
        pvd_step(1'b0, 1'b1);
        tally_and_finish();
    end
endmodule : tb_power_mode_controller
`default_nettype wire
